// file: core/iouar_latch.sv
// Register stage: nine latches with odd-parity reset value
`timescale 1ns/100ps
module iouar_latch (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Load control
  iouar_load_if.regs ld,
  // Held value
  output logic [8:0] value_q
);
  import iouar_pkg::*;
  logic [8:0] value_d;

  always_comb begin
    value_d = value_q; // R16
    if (ld.clear) begin
      value_d = {IOUAR_PAR_RST, IOUAR_DATA_RST}; // R14
    end else if (ld.capture) begin
      value_d = ld.data; // R14
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      value_q <= {IOUAR_PAR_RST, IOUAR_DATA_RST}; // R13
    end else begin
      value_q <= value_d;
    end
  end
endmodule

// file: core/iouar_load_if.sv
// Interface: load request from sequencer to the register stage
`timescale 1ns/100ps
interface iouar_load_if;
  import iouar_pkg::*;
  logic clear;
  logic capture;
  logic [8:0] data;
  modport seq (output clear, output capture, output data);
  modport regs (input clear, input capture, input data);
endinterface

// file: core/iouar_pkg.sv
// Package: widths, reset values and condition codes for the unit address register
package iouar_pkg;
  localparam int IOUAR_DATA_W = 8;
  localparam int IOUAR_REG_W = 9;
  localparam int IOUAR_PAR_BIT = 8;
  localparam logic [7:0] IOUAR_DATA_RST = 8'h00;
  localparam logic IOUAR_PAR_RST = 1'b1;
  localparam logic [1:0] IOUAR_CC_OK = 2'h0;
  localparam logic [1:0] IOUAR_CC_BUSY = 2'h2;
  // Load sources
  typedef enum logic [1:0] {
    IOUAR_SRC_NONE,
    IOUAR_SRC_CPU,
    IOUAR_SRC_PANEL,
    IOUAR_SRC_BUSIN
  } iouar_src_t;
  // Two-phase load: clear cycle, then capture cycle
  typedef enum logic [1:0] {
    IOUAR_IDLE,
    IOUAR_CLEAR,
    IOUAR_CAPTURE
  } iouar_state_t;
endpackage

// file: core/iouar_unit.sv
// Top: I/O unit address register with ingating, compare and outgating
//
// What this block does
// R1: Hold an eight-bit unit address plus one parity bit.
// R2: Load CPU address lines for start, test, halt (channel free), INITIAL_PROGRAM_LOAD, fault test.
// R3: On a polled I/O interruption load the address from the bus-in latches.
// R4: Auto mode gates CPU lines; test mode gates panel switches instead.
// R5: Bus-in bits load only while the bus-in gating signal is active.
// R6: During setup compare register with bus-in; match keeps check inactive.
// R7: Mismatch sampled in setup raises interface control check and terminates.
// R8: Test I/O with pending interrupt and mismatch: address check, busy code, end.
// R9: Test I/O match continues and loads the CPU address, clearing the interrupt; the code does not clear interrupt_pending.
// R10: Copy register to the bus-out latches when device selection is required; the code copies only while busy_ready, not during a load.
// R11: Drive register onto storage input lines for logout word two and INITIAL_PROGRAM_LOAD end.
// R12: In test mode ignore the processor side; use panel or I/O side only.
// R13: Reset clears data bits and sets parity to one.
// R14: Every load first clears the register, then captures after the clear.
// R15: CPU accept interrupt suppresses CPU loads for test or halt I/O.
// R16: With no load gating the register keeps its value.
`timescale 1ns/100ps
module iouar_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Mode
  input wire logic test_mode,
  // Processor side
  input wire logic [8:0] cpu_unit_addr,
  input wire logic start_io,
  input wire logic test_io,
  input wire logic halt_io,
  input wire logic channel_free,
  input wire logic initial_program_load,
  input wire logic fault_locating_test,
  input wire logic cpu_accept_interrupt,
  input wire logic interrupt_pending,
  input wire logic test_io_compare,
  // Panel
  input wire logic [8:0] panel_unit_addr,
  input wire logic panel_gate,
  // I/O side
  input wire logic [8:0] bus_in_latches,
  input wire logic gate_bus_in,
  input wire logic setup_compare,
  input wire logic select_required,
  // Storage side
  input wire logic logout_word2,
  input wire logic ipl_end,
  // Results
  output logic [8:0] unit_addr,
  output logic busy_ready,
  output logic data_bus_compare_check,
  output logic interface_control_check,
  output logic terminate_io,
  output logic unit_address_check,
  output logic [1:0] busy_condition_code,
  output logic test_io_continue,
  output logic [8:0] bus_out_latches,
  output logic bus_out_load,
  output logic [8:0] storage_input_lines,
  output logic storage_input_valid
);
  import iouar_pkg::*;

  // ------------------------------------------------------------
  // Load sequencing
  // ------------------------------------------------------------
  iouar_load_if ld ();
  iouar_state_t state_q, state_d;
  logic [8:0] pend_q, pend_d;
  logic req_cpu, req_panel, req_bus, tio_match, tio_check;
  logic [8:0] req_data;

  function automatic logic addr_equal(input logic [8:0] a, input logic [8:0] b);
    addr_equal = (a[IOUAR_DATA_W-1:0] == b[IOUAR_DATA_W-1:0]);
  endfunction

  // Test I/O compare against held address
  always_comb begin
    tio_check = 1'b0;
    tio_match = 1'b0;
    if (!test_mode && test_io_compare && interrupt_pending) begin
      tio_check = !addr_equal(cpu_unit_addr, unit_addr); // R8
      tio_match = addr_equal(cpu_unit_addr, unit_addr); // R9
    end
  end

  // Source selection; processor side is dead in test mode
  always_comb begin
    req_cpu = 1'b0;
    if (!test_mode) begin // R12
      req_cpu = start_io || initial_program_load || fault_locating_test; // R2
      if ((test_io || (halt_io && channel_free)) && !cpu_accept_interrupt) begin // R15
        req_cpu = 1'b1; // R2
      end
      if (test_io_compare && interrupt_pending && !tio_match) begin
        req_cpu = 1'b0; // R8
      end
      if (tio_match && !cpu_accept_interrupt) begin
        req_cpu = 1'b1; // R9
      end
    end
    req_panel = test_mode && panel_gate; // R4
    req_bus = gate_bus_in; // R3 R5
    req_data = bus_in_latches;
    if (req_cpu) begin
      req_data = cpu_unit_addr; // R4
    end else if (req_panel) begin
      req_data = panel_unit_addr; // R4
    end
  end

  always_comb begin
    state_d = state_q;
    pend_d = pend_q;
    ld.clear = 1'b0;
    ld.capture = 1'b0;
    ld.data = pend_q;
    unique case (state_q)
      IOUAR_IDLE: begin
        if (req_cpu || req_panel || req_bus) begin
          pend_d = req_data;
          state_d = IOUAR_CLEAR;
        end
      end
      IOUAR_CLEAR: begin
        ld.clear = 1'b1; // R14
        state_d = IOUAR_CAPTURE;
      end
      IOUAR_CAPTURE: begin
        ld.capture = 1'b1; // R14
        state_d = IOUAR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= IOUAR_IDLE;
      pend_q <= {IOUAR_PAR_RST, IOUAR_DATA_RST};
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
    end
  end

  iouar_latch u_latch (
    .clock(clock),
    .reset(reset),
    .ld(ld),
    .value_q(unit_addr) // R1
  );

  assign busy_ready = (state_q == IOUAR_IDLE);

  // ------------------------------------------------------------
  // Checks and outgating
  // ------------------------------------------------------------
  logic dbc_d, icc_d, uac_d, cont_d, bol_d, siv_d;
  logic [1:0] cc_d;
  logic [8:0] bo_d, sil_d;
  logic dbc_q, icc_q, uac_q, cont_q, bol_q, siv_q;
  logic [1:0] cc_q;
  logic [8:0] bo_q, sil_q;

  always_comb begin
    dbc_d = setup_compare && !addr_equal(bus_in_latches, unit_addr); // R6 R7
    icc_d = dbc_d; // R7
    uac_d = tio_check; // R8
    cc_d = tio_check ? IOUAR_CC_BUSY : IOUAR_CC_OK; // R8
    cont_d = tio_match; // R9
    bol_d = select_required && busy_ready; // R10
    bo_d = bol_d ? unit_addr : bo_q; // R10
    siv_d = logout_word2 || ipl_end; // R11
    sil_d = siv_d ? unit_addr : {IOUAR_REG_W{1'b0}}; // R11
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dbc_q <= 1'b0;
      icc_q <= 1'b0;
      uac_q <= 1'b0;
      cc_q <= IOUAR_CC_OK;
      cont_q <= 1'b0;
      bol_q <= 1'b0;
      bo_q <= {IOUAR_REG_W{1'b0}};
      siv_q <= 1'b0;
      sil_q <= {IOUAR_REG_W{1'b0}};
    end else begin
      dbc_q <= dbc_d;
      icc_q <= icc_d;
      uac_q <= uac_d;
      cc_q <= cc_d;
      cont_q <= cont_d;
      bol_q <= bol_d;
      bo_q <= bo_d;
      siv_q <= siv_d;
      sil_q <= sil_d;
    end
  end

  assign data_bus_compare_check = dbc_q;
  assign interface_control_check = icc_q;
  assign terminate_io = icc_q || uac_q; // R7 R8
  assign unit_address_check = uac_q;
  assign busy_condition_code = cc_q;
  assign test_io_continue = cont_q;
  assign bus_out_latches = bo_q;
  assign bus_out_load = bol_q;
  assign storage_input_lines = sil_q;
  assign storage_input_valid = siv_q;
endmodule

// file: verification/iouar_cu_model.sv
// Control unit stand-in: answers a selection with an address byte
`timescale 1ns/100ps
module iouar_cu_model (
  // Clock
  input wire logic clock,
  // Selection from the channel, and a wrong-device switch
  input wire logic bus_out_load,
  input wire logic [8:0] bus_out_latches,
  input wire logic wrong,
  // Reply
  output logic [8:0] bus_in_latches = 9'h0a5
);
  // Outside the reply cycle the bus inverts every clock, so a stale address shows only on alternate cycles
  always_ff @(posedge clock) begin
    if (bus_out_load) begin
      bus_in_latches <= bus_out_latches ^ {1'b0, {8{wrong}}};
    end else begin
      bus_in_latches <= ~bus_in_latches;
    end
  end
endmodule

// file: verification/iouar_unit_bench.sv
// Self-checking bench for the unit address register
`timescale 1ns/100ps
module iouar_unit_bench;
  import iouar_pkg::*;
  logic clock = 0, reset = 1, test_mode = 0, start_io = 0, test_io = 0, halt_io = 0;
  logic channel_free = 1, initial_program_load = 0, fault_locating_test = 0, wrong = 0;
  logic cpu_accept_interrupt = 0, interrupt_pending = 0, test_io_compare = 0, ipl_end = 0;
  logic panel_gate = 0, gate_bus_in = 0, setup_compare = 0, select_required = 0;
  logic logout_word2 = 0, busy_ready, data_bus_compare_check, interface_control_check;
  logic terminate_io, unit_address_check, test_io_continue, bus_out_load, storage_input_valid;
  logic [1:0] busy_condition_code;
  logic [8:0] cpu_unit_addr = 0, panel_unit_addr = 0, bus_in_latches, unit_addr, m, e;
  logic [8:0] bus_out_latches, storage_input_lines;
  logic [31:0] r = 32'h1958;
  int fail_count = 0, checked = 0;
  iouar_unit iouar_unit_inst (.*);
  iouar_cu_model iouar_cu_model_inst (.*);
  always #12.5 clock = ~clock;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input string n, input logic [8:0] s, input logic [8:0] x);
    checked++;
    if (s !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  // One load request, then the clear cycle and the capture cycle
  task ld(input logic [8:0] a, input int k, input logic [8:0] e1, input logic [8:0] e2);
    cpu_unit_addr = a;
    panel_unit_addr = a;
    {panel_gate, fault_locating_test, initial_program_load, halt_io, test_io, start_io} = 6'(1 << k);
    @(posedge clock) #2;
    {panel_gate, fault_locating_test, initial_program_load, halt_io, test_io, start_io} = 6'h00;
    @(posedge clock) #2 chk("clear", unit_addr, e1);
    @(posedge clock) #2 chk("load", unit_addr, e2);
  endtask
  task results;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000 fail_count++;
    results;
  end
  initial begin
    repeat (12) @(posedge clock);
    #2 reset = 0;
    m = 9'h100;
    chk("reset", unit_addr, m);
    for (int k = 0; k < 5; k++) begin
      r = lfsr(r);
      ld(r[8:0], k, 9'h100, r[8:0]);
      m = r[8:0];
    end
    channel_free = 0;
    ld(~m, 2, m, m);
    channel_free = 1;
    cpu_accept_interrupt = 1;
    ld(~m, 1, m, m);
    ld(~m, 2, m, m);
    cpu_accept_interrupt = 0;
    ld(~m, 5, m, m);
    test_mode = 1;
    ld(~m, 0, m, m);
    ld(~m, 5, 9'h100, ~m);
    m = ~m;
    for (int w = 0; w < 2; w++) begin
      wrong = w[0];
      select_required = 1;
      @(posedge clock) #2 select_required = 0;
      chk("bus out", bus_out_latches, m);
      chk("bus out load", 9'(bus_out_load), 9'h001);
      @(posedge clock) #2 e = m ^ {1'b0, {8{wrong}}};
      {setup_compare, gate_bus_in} = 2'h3;
      @(posedge clock) #2 {setup_compare, gate_bus_in} = 2'h0;
      chk("check", 9'(interface_control_check), 9'(wrong));
      chk("compare check", 9'(data_bus_compare_check), 9'(wrong));
      @(posedge clock);
      @(posedge clock) #2 chk("bus in", unit_addr, e);
      m = e;
      @(posedge clock) #2;
    end
    {test_mode, interrupt_pending, test_io_compare} = 3'h3;
    ld(m ^ 9'h001, 1, m, m);
    chk("address check", 9'(unit_address_check), 9'h001);
    chk("busy code", 9'(busy_condition_code), 9'(IOUAR_CC_BUSY));
    chk("terminate", 9'(terminate_io), 9'h001);
    ld({~m[8], m[7:0]}, 1, 9'h100, {~m[8], m[7:0]});
    m = {~m[8], m[7:0]};
    cpu_accept_interrupt = 1;
    @(posedge clock) #2 chk("continue", 9'(test_io_continue), 9'h001);
    chk("no address check", 9'(unit_address_check), 9'h000);
    cpu_accept_interrupt = 0;
    {interrupt_pending, test_io_compare} = 2'h0;
    for (int i = 0; i < 2; i++) begin
      {ipl_end, logout_word2} = 2'(1 << i);
      @(posedge clock) #2 {ipl_end, logout_word2} = 2'h0;
      chk("store", storage_input_lines, m);
      chk("store valid", 9'(storage_input_valid), 9'h001);
      @(posedge clock) #2;
    end
    results;
  end
endmodule
bind iouar_unit iouar_unit_sva iouar_unit_sva_inst (.*);

// file: verification/iouar_unit_sva.sv
// Checker on the unit address register ports
`timescale 1ns/100ps
module iouar_unit_sva
  import iouar_pkg::*;
(
  // Clock, reset, inputs and outputs watched
  input wire logic clock, reset, test_mode, start_io, panel_gate, gate_bus_in,
  input wire logic interrupt_pending, test_io_compare, setup_compare, select_required,
  input wire logic logout_word2, ipl_end, busy_ready, data_bus_compare_check,
  input wire logic interface_control_check, terminate_io, unit_address_check,
  input wire logic bus_out_load, storage_input_valid,
  input wire logic [1:0] busy_condition_code,
  input wire logic [8:0] cpu_unit_addr, bus_in_latches, unit_addr,
  input wire logic [8:0] bus_out_latches, storage_input_lines
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_setup_match: assert property (
    setup_compare && unit_addr[7:0] == bus_in_latches[7:0] |=> !data_bus_compare_check)
    else $error("compare check on match");
  a_setup_miss: assert property (
    setup_compare && unit_addr[7:0] != bus_in_latches[7:0]
    |=> interface_control_check && terminate_io) else $error("no check on mismatch");
  a_tio_miss: assert property (
    test_io_compare && interrupt_pending && !test_mode && cpu_unit_addr[7:0] != unit_addr[7:0]
    |=> unit_address_check && busy_condition_code == IOUAR_CC_BUSY) else $error("no busy code");
  a_bus_out: assert property (
    select_required && busy_ready |=> bus_out_load && bus_out_latches == $past(unit_addr))
    else $error("bus out copy wrong");
  a_store_out: assert property (
    logout_word2 || ipl_end |=> storage_input_valid && storage_input_lines == $past(unit_addr))
    else $error("storage lines wrong");
  a_cpu_load: assert property (
    !test_mode && busy_ready && start_io && !(test_io_compare && interrupt_pending)
    |=> ##1 unit_addr == 9'h100 ##1 unit_addr == $past(cpu_unit_addr, 3))
    else $error("cpu load");
  a_load_busy: assert property (
    !test_mode && busy_ready && start_io && !(test_io_compare && interrupt_pending)
    |=> !busy_ready ##1 !busy_ready ##1 busy_ready) else $error("loader busy");
  a_busin_load: assert property (
    test_mode && busy_ready && gate_bus_in && !panel_gate
    |=> ##1 unit_addr == 9'h100 ##1 unit_addr == $past(bus_in_latches, 3))
    else $error("bus in load");
  a_test_hold: assert property (
    test_mode && busy_ready && !panel_gate && !gate_bus_in |=> $stable(unit_addr))
    else $error("register moved");
  c_miss: cover property (setup_compare ##1 interface_control_check);
  c_tio: cover property (test_io_compare ##1 unit_address_check);
  c_busin: cover property (gate_bus_in && busy_ready);
endmodule
